// file: common/pcp_pkg.sv
package pcp_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHAR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_CODE = 8'h14;
  localparam logic [7:0] OFS_MANT = 8'h18;
  localparam logic [7:0] OFS_EXP = 8'h1C;
  localparam logic [7:0] OFS_PFX_MANT = 8'h20;
  localparam logic [7:0] OFS_PFX_EXP = 8'h24;
  localparam logic [7:0] OFS_SETTINGS = 8'h28;
  // Interrupt status and mask bits
  localparam int INT_W = 4;
  localparam int INT_EXEC = 0;
  localparam int INT_TRIG = 1;
  localparam int INT_ERR = 2;
  localparam int INT_AUTO = 3;
  // Settings bits
  localparam int SET_PREDISP = 0;
  localparam int SET_DEEMPH = 1;
  localparam int SET_RMS = 5;
  localparam int SET_AUTO = 6;
  localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
  localparam logic [7:0] ERR_INVALID_CODE = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int MANT_DIGITS = 8;
  localparam int EXP_DIGITS = 2;
  // Characters and two-character codes, upper case
  localparam logic [7:0] CH_EXP = 8'h45;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DEEMPH = 8'h50;
  localparam logic [7:0] CH_DETECT = 8'h44;
  localparam logic [15:0] CODE_AUTO = 16'h4155;
  localparam logic [15:0] CODE_SPECIAL = 16'h5350;
  localparam logic [15:0] CODE_PREDISP_OFF = 16'h5030;
  localparam logic [15:0] CODE_RMS_DET = 16'h4438;
  localparam logic [15:0] CODE_TRIG_NOW = 16'h5432;
  localparam logic [15:0] CODE_TRIG_SETTLED = 16'h5433;
  typedef enum logic [2:0] {
    CL_DIGIT = 3'b000, CL_POINT = 3'b001, CL_SIGN = 3'b010,
    CL_LETTER = 3'b011, CL_IGNORE = 3'b100, CL_INVALID = 3'b101
  } pcp_class_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_MANT = 2'b01, ST_EXP = 2'b10, ST_CODE = 2'b11
  } pcp_state_t;
endpackage

// file: logic/pcp_char_class.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_char_class
  import pcp_pkg::*;
(
  // Raw character
  input wire logic [7:0] raw,
  // Folded character and its class
  output logic [7:0] folded,
  output pcp_class_t cls
);
  logic is_lower;
  logic is_upper;
  logic is_digit;
  logic is_ignore;
  assign is_lower = (raw >= 8'h61) && (raw <= 8'h7A);
  assign is_upper = (raw >= 8'h41) && (raw <= 8'h5A);
  assign is_digit = (raw >= 8'h30) && (raw <= 8'h39);
  assign is_ignore = ((raw >= 8'h20) && (raw <= 8'h2A)) || (raw == 8'h2C)
    || (raw == 8'h2F) || (raw == 8'h0D) || (raw == 8'h0A);
  assign folded = is_lower ? (raw - 8'h20) : raw;
  assign cls = is_digit ? CL_DIGIT :
               (raw == 8'h2E) ? CL_POINT :
               ((raw == 8'h2B) || (raw == CH_MINUS)) ? CL_SIGN :
               (is_lower || is_upper) ? CL_LETTER :
               is_ignore ? CL_IGNORE : CL_INVALID;
endmodule
`default_nettype wire

// file: logic/pcp_num_acc.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_num_acc
  import pcp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // Controls from the parser
  input wire logic clear,
  input wire logic dig_en,
  input wire logic [3:0] dig,
  input wire logic pt_en,
  input wire logic neg_en,
  input wire logic exp_dig_en,
  input wire logic exp_neg_en,
  // Normalised value
  output logic [31:0] mant,
  output logic mant_neg,
  output logic [7:0] exp_total,
  output logic [3:0] ndig,
  output logic has_pt,
  output logic [1:0] nexp
);
  logic [3:0] int_over;
  logic [3:0] frac;
  logic [6:0] exp_mag;
  logic exp_neg;
  logic full;
  logic [7:0] exp_signed;
  assign full = (ndig >= 4'(MANT_DIGITS));
  assign exp_signed = exp_neg ? (8'h00 - {1'b0, exp_mag}) : {1'b0, exp_mag};
  assign exp_total = exp_signed + {4'h0, int_over} - {4'h0, frac};
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      mant <= 32'h0000_0000;
      mant_neg <= 1'b0;
      ndig <= 4'h0;
      has_pt <= 1'b0;
      int_over <= 4'h0;
      frac <= 4'h0;
      exp_mag <= 7'h00;
      exp_neg <= 1'b0;
      nexp <= 2'b00;
    end else begin
      if (neg_en) begin
        mant_neg <= 1'b1;
      end
      if (pt_en) begin
        has_pt <= 1'b1;
        if (ndig == 4'h0) begin
          ndig <= 4'h1;
        end
      end
      if (dig_en && !full) begin
        mant <= {mant[27:0], dig};
        ndig <= ndig + 4'h1;
        frac <= has_pt ? frac + 4'h1 : frac;
      end
      if (dig_en && full && !has_pt && int_over != 4'hF) begin
        int_over <= int_over + 4'h1;
      end
      if (exp_dig_en) begin
        exp_mag <= 7'(exp_mag * 7'd10 + {3'h0, dig});
        nexp <= nexp + 2'b01;
      end
      if (exp_neg_en) begin
        exp_neg <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/pcp_parser.sv
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pcp_parser
  import pcp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Executed code
  output logic exec_valid,
  output logic [15:0] exec_code,
  output logic exec_has_arg,
  output logic [31:0] exec_mant,
  output logic exec_neg,
  output logic [7:0] exec_exp,
  output logic exec_has_prefix,
  output logic [31:0] prefix_mant,
  output logic [7:0] prefix_exp,
  // Instrument actions
  output logic measure_start,
  output logic special_zero,
  output logic predisplay_on,
  output logic [3:0] deemph_sel,
  output logic rms_detector,
  output logic auto_mode,
  // Errors and interrupt
  output logic srq,
  output logic irq
);
  // Bus holding registers
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_word;
  logic char_we;
  logic ctrl_we;
  logic stat_we;
  logic mask_we;
  // Parser state
  pcp_state_t state;
  pcp_state_t next_state;
  logic [7:0] first;
  logic [7:0] next_first;
  logic prefix_valid;
  logic [7:0] err_code;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_ev;
  logic [INT_W-1:0] int_clr;
  // Character decode
  logic [7:0] ch;
  pcp_class_t cls;
  logic [15:0] code;
  logic is_exp_letter;
  // Accumulator handshake
  logic acc_clr;
  logic dig_en;
  logic pt_en;
  logic neg_en;
  logic exp_dig_en;
  logic exp_neg_en;
  logic [31:0] mant;
  logic mant_neg;
  logic [7:0] exp_total;
  logic [3:0] ndig;
  logic has_pt;
  logic [1:0] nexp;
  // Events
  logic ev_exec;
  logic ev_prefix;
  logic ev_err;
  logic ev_srq;
  logic do_code;
  logic is_trig;
  logic is_deemph;
  logic is_detect;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= ADDR_W'(OFS_SETTINGS));
  endfunction

  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(s_axi_araddr);
  assign char_we = wr_fire && wr_addr == ADDR_W'(OFS_CHAR) && wr_strb[0];
  assign ctrl_we = wr_fire && wr_addr == ADDR_W'(OFS_CTRL) && wr_strb[0];
  assign stat_we = wr_fire && wr_addr == ADDR_W'(OFS_INT_STAT);
  assign mask_we = wr_fire && wr_addr == ADDR_W'(OFS_INT_MASK);

  pcp_char_class u_class (
    .raw(wr_data[7:0]),
    .folded(ch),
    .cls(cls)
  );

  pcp_num_acc u_acc (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(acc_clr),
    .dig_en(dig_en),
    .dig(ch[3:0]),
    .pt_en(pt_en),
    .neg_en(neg_en),
    .exp_dig_en(exp_dig_en),
    .exp_neg_en(exp_neg_en),
    .mant(mant),
    .mant_neg(mant_neg),
    .exp_total(exp_total),
    .ndig(ndig),
    .has_pt(has_pt),
    .nexp(nexp)
  );

  assign code = {first, ch};
  assign is_exp_letter = (ch == CH_EXP) && (ndig != 4'h0);
  assign is_trig = code == CODE_TRIG_NOW || code == CODE_TRIG_SETTLED;
  assign is_deemph = first == CH_DEEMPH && ch >= 8'h31 && ch <= 8'h34;
  assign is_detect = first == CH_DETECT && cls == CL_DIGIT;
  assign int_clr = stat_we && wr_strb[0] ? wr_data[INT_W-1:0] : '0;
  assign int_ev = {ev_exec && code == CODE_AUTO, ev_err,
                   ev_exec && is_trig, ev_exec};

  // Character-by-character parse
  always_comb begin
    next_state = state;
    next_first = first;
    acc_clr = 1'b0;
    dig_en = 1'b0;
    pt_en = 1'b0;
    neg_en = 1'b0;
    exp_dig_en = 1'b0;
    exp_neg_en = 1'b0;
    do_code = 1'b0;
    ev_err = 1'b0;
    ev_srq = 1'b0;
    if (ctrl_we && wr_data[0]) begin
      next_state = ST_IDLE;
      acc_clr = 1'b1;
    end else if (char_we) begin
      case (cls)
        CL_INVALID: begin
          ev_err = 1'b1;
          ev_srq = 1'b1;
          acc_clr = 1'b1;
          next_state = ST_IDLE;
        end
        CL_IGNORE: begin
          if (state == ST_CODE) begin
            ev_err = 1'b1;
            acc_clr = 1'b1;
            next_state = ST_IDLE;
          end
        end
        CL_LETTER: begin
          if (state == ST_CODE) begin
            do_code = 1'b1;
            next_state = ST_IDLE;
          end else if (state == ST_MANT && is_exp_letter) begin
            next_state = ST_EXP;
          end else begin
            next_first = ch;
            next_state = ST_CODE;
          end
        end
        CL_DIGIT: begin
          if (state == ST_CODE) begin
            do_code = 1'b1;
            next_state = ST_IDLE;
          end else if (state == ST_EXP) begin
            exp_dig_en = nexp < 2'(EXP_DIGITS);
            ev_err = nexp >= 2'(EXP_DIGITS);
          end else begin
            dig_en = 1'b1;
            next_state = ST_MANT;
          end
        end
        CL_POINT: begin
          if (state == ST_IDLE || (state == ST_MANT && !has_pt)) begin
            pt_en = 1'b1;
            next_state = ST_MANT;
          end else begin
            ev_err = 1'b1;
          end
        end
        CL_SIGN: begin
          if (state == ST_IDLE) begin
            neg_en = ch == CH_MINUS;
            next_state = ST_MANT;
          end else if (state == ST_EXP && nexp == 2'b00) begin
            exp_neg_en = ch == CH_MINUS;
          end else begin
            ev_err = 1'b1;
          end
        end
        default: begin
          ev_err = 1'b1;
        end
      endcase
    end
    if (do_code) begin
      acc_clr = 1'b1;
    end
  end

  assign ev_prefix = do_code && code == CODE_SPECIAL && ndig != 4'h0;
  assign ev_exec = do_code && !ev_prefix;

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read data selection
  always_comb begin
    case (s_axi_araddr)
      ADDR_W'(OFS_STATUS): rd_word = {16'h0000, err_code, 3'b000,
        prefix_valid, 2'b00, state};
      ADDR_W'(OFS_INT_STAT): rd_word = {28'h000_0000, int_stat};
      ADDR_W'(OFS_INT_MASK): rd_word = {28'h000_0000, int_mask};
      ADDR_W'(OFS_CODE): rd_word = {15'h0000, exec_has_arg, exec_code};
      ADDR_W'(OFS_MANT): rd_word = exec_mant;
      ADDR_W'(OFS_EXP): rd_word = {23'h00_0000, exec_neg, exec_exp};
      ADDR_W'(OFS_PFX_MANT): rd_word = prefix_mant;
      ADDR_W'(OFS_PFX_EXP): rd_word = {24'h00_0000, prefix_exp};
      ADDR_W'(OFS_SETTINGS): rd_word = {25'h000_0000, auto_mode,
        rms_detector, deemph_sel, predisplay_on};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Parser state, interrupts and errors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      first <= 8'h00;
      err_code <= 8'h00;
      int_stat <= '0;
      int_mask <= INT_MASK_RST;
      srq <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      first <= next_first;
      err_code <= ev_err ? ERR_INVALID_CODE : err_code;
      // Set wins over a same-cycle clear
      int_stat <= (int_stat & ~int_clr) | int_ev;
      if (mask_we && wr_strb[0]) begin
        int_mask <= wr_data[INT_W-1:0];
      end
      srq <= ev_srq;
      irq <= |(((int_stat & ~int_clr) | int_ev) & int_mask);
    end
  end

  // Prefix and executed code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prefix_valid <= 1'b0;
      prefix_mant <= 32'h0000_0000;
      prefix_exp <= 8'h00;
      exec_valid <= 1'b0;
      exec_code <= 16'h0000;
      exec_has_arg <= 1'b0;
      exec_mant <= 32'h0000_0000;
      exec_neg <= 1'b0;
      exec_exp <= 8'h00;
      exec_has_prefix <= 1'b0;
    end else begin
      exec_valid <= ev_exec;
      if (ev_prefix) begin
        prefix_valid <= 1'b1;
        prefix_mant <= mant;
        prefix_exp <= exp_total;
      end else if (ev_exec || ev_err) begin
        prefix_valid <= 1'b0;
      end
      if (ev_exec) begin
        exec_code <= code;
        exec_has_arg <= ndig != 4'h0;
        exec_mant <= mant;
        exec_neg <= mant_neg;
        exec_exp <= exp_total;
        exec_has_prefix <= prefix_valid;
      end
    end
  end

  // Instrument settings driven by codes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      measure_start <= 1'b0;
      special_zero <= 1'b0;
      predisplay_on <= 1'b0;
      deemph_sel <= 4'h0;
      rms_detector <= 1'b0;
      auto_mode <= 1'b0;
    end else begin
      measure_start <= ev_exec && is_trig;
      special_zero <= ev_exec && code == CODE_AUTO;
      if (ev_exec && code == CODE_AUTO) begin
        auto_mode <= 1'b1;
      end
      if (ev_exec && is_detect) begin
        rms_detector <= code == CODE_RMS_DET;
      end
      if (ev_exec && code == CODE_PREDISP_OFF) begin
        deemph_sel <= 4'h0;
        predisplay_on <= rms_detector;
      end
      if (ev_exec && is_deemph) begin
        predisplay_on <= 1'b1;
        deemph_sel[ch[1:0] - 2'b01] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/pcp_parser_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_parser_props
  import pcp_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Parser outputs
  input wire logic exec_valid,
  input wire logic [15:0] exec_code,
  input wire logic measure_start,
  input wire logic special_zero,
  input wire logic predisplay_on,
  input wire logic [3:0] deemph_sel,
  input wire logic rms_detector,
  input wire logic auto_mode,
  input wire logic srq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire is_trig = exec_valid && (exec_code == CODE_TRIG_NOW ||
    exec_code == CODE_TRIG_SETTLED);
  wire is_pd_off = exec_valid && exec_code == CODE_PREDISP_OFF;
  wire is_det = exec_valid && exec_code[15:8] == CH_DETECT;

  a_trig_start: assert property (measure_start == is_trig)
    else $error("measure start does not follow trigger code");
  a_auto_pulse: assert property (
    special_zero == (exec_valid && exec_code == CODE_AUTO))
    else $error("special zero does not follow auto code");
  a_auto_mode: assert property (special_zero |=> auto_mode)
    else $error("auto mode not set");
  a_pdoff_deemph: assert property (
    is_pd_off |=> deemph_sel == 4'h0)
    else $error("de-emphasis left on after predisplay off");
  a_pdoff_keep: assert property (
    is_pd_off |=> predisplay_on == rms_detector)
    else $error("predisplay wrong after predisplay off");
  a_rms_select: assert property (
    is_det |=> rms_detector == ($past(exec_code) == CODE_RMS_DET))
    else $error("rms detector selection wrong");
  a_exec_resp: assert property (exec_valid |-> $rose(s_axi_bvalid))
    else $error("execution without character response");
  a_srq_resp: assert property (
    srq |-> $rose(s_axi_bvalid) && !exec_valid)
    else $error("service request not tied to character");
  a_aw_refuse: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("write address accepted twice");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule
`default_nettype wire

// file: bench/pcp_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcp_host
  import pcp_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Write channels
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  assign s_axi_awprot = 3'h0;
  assign s_axi_arprot = 3'h0;
  assign s_axi_wstrb = 4'hF;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 1'h0;
    w_d = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw_d) begin
        aw_d = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !w_d) begin
        w_d = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic send(input string s);
    logic [1:0] r;
    for (int i = 0; i < s.len(); i++) begin
      wr(OFS_CHAR, {24'h00_0000, s[i]}, r);
    end
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// file: bench/program_code_parser_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module program_code_parser_tb_top
  import pcp_pkg::*;
();
  logic aclk, aresetn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, exec_mant, prefix_mant;
  logic [3:0] s_axi_wstrb, deemph_sel;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, exec_valid, exec_has_arg, exec_neg;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] exec_code;
  logic [7:0] exec_exp, prefix_exp;
  logic exec_has_prefix, measure_start, special_zero, predisplay_on;
  logic rms_detector, auto_mode, srq, irq;
  int miscompares, tests_run, n_exec, n_meas, n_spz, n_srq;

  pcp_parser i_dut (.*);
  pcp_host i_host (.*);

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // Pulse counters
  always @(posedge aclk) begin
    n_exec <= n_exec + int'(exec_valid === 1'h1);
    n_meas <= n_meas + int'(measure_start === 1'h1);
    n_spz <= n_spz + int'(special_zero === 1'h1);
    n_srq <= n_srq + int'(srq === 1'h1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic num(input string s, input logic [15:0] c, input logic a,
                     input logic [31:0] m, input logic [7:0] x,
                     input logic n);
    int e;
    e = n_exec;
    i_host.send(s);
    chk(n_exec - e, 32'h1);
    chk(exec_code, c);
    chk(exec_has_arg, a);
    if (a) begin
      chk(exec_mant, m);
      chk(exec_exp, x);
      chk(exec_neg, n);
    end
  endtask

  task automatic t_forms();
    num("100MZ", 16'h4D5A, 1'h1, 32'h0000_0100, 8'h00, 1'h0);
    num("mz", 16'h4D5A, 1'h0, 32'h0, 8'h0, 1'h0);
    num(" ,CF", 16'h4346, 1'h0, 32'h0, 8'h0, 1'h0);
    num("-12e-3cf", 16'h4346, 1'h1, 32'h0000_0012, 8'hFD, 1'h1);
    num(".1234567899999CF", 16'h4346, 1'h1, 32'h0123_4567, 8'hF9,
        1'h0);
    num("1234567890CF", 16'h4346, 1'h1, 32'h1234_5678, 8'h02,
        1'h0);
    num("27.3SP100MZ", 16'h4D5A, 1'h1, 32'h0000_0100, 8'h00, 1'h0);
    chk(exec_has_prefix, 1'h1);
    chk(prefix_mant, 32'h0000_0273);
    chk(prefix_exp, 8'hFF);
    num("MZ", 16'h4D5A, 1'h0, 32'h0, 8'h0, 1'h0);
    chk(exec_has_prefix, 1'h0);
    $display("t_forms done");
  endtask

  task automatic t_modes();
    int s, m;
    s = n_spz;
    m = n_meas;
    i_host.send("AU104.5MZM2D1P1P4T3");
    chk(n_spz - s, 32'h1);
    chk(auto_mode, 1'h1);
    chk(deemph_sel, 4'h9);
    chk(n_meas - m, 32'h1);
    i_host.send("D8P0");
    chk(deemph_sel, 4'h0);
    chk(predisplay_on, 1'h1);
    i_host.send("D1P1P0");
    chk(predisplay_on, 1'h0);
    i_host.send("T2");
    chk(n_meas - m, 32'h2);
    $display("t_modes done");
  endtask

  task automatic t_errors();
    logic [31:0] d;
    logic [1:0] r;
    int q;
    i_host.rd(OFS_INT_MASK, d, r);
    chk(d, 32'h0);
    i_host.wr(OFS_INT_STAT, 32'h0000_000F, r);
    i_host.wr(OFS_INT_MASK, 32'h0000_0004, r);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h0);
    q = n_exec;
    i_host.send("M 3");
    chk(n_exec - q, 32'h0);
    chk(irq, 1'h1);
    i_host.rd(OFS_STATUS, d, r);
    chk(d[15:8], ERR_INVALID_CODE);
    i_host.wr(OFS_INT_STAT, 32'h0000_0004, r);
    repeat (2) @(posedge aclk);
    chk(irq, 1'h0);
    i_host.wr(OFS_CTRL, 32'h0000_0001, r);
    i_host.send("CF");
    chk(exec_has_arg, 1'h0);
    chk(irq, 1'h0);
    q = n_srq;
    i_host.send("@");
    chk(n_srq - q, 32'h1);
    chk(irq, 1'h1);
    i_host.rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    i_host.wr(8'h40, 32'h0, r);
    chk(r, RESP_SLVERR);
    $display("t_errors done");
  endtask

  task automatic end_sim();
    $display("Compared %0d, mismatched %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_forms();
    t_modes();
    t_errors();
    end_sim();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_sim();
  end
endmodule
bind pcp_parser pcp_parser_props i_props (.*);
`default_nettype wire
